// ---- include/aisl_pkg.sv ----
// Constants, field layout and mode codes of the event interrupt block.
package aisl_pkg;

    localparam int unsigned DATA_W = 8;

    // Register indices; the byte address is four times the index.
    localparam logic [5:0] IDX_POLARITY = 6'h0C;
    localparam logic [5:0] IDX_STATUS   = 6'h0D;
    localparam logic [5:0] IDX_MASK     = 6'h0E;
    localparam logic [5:0] IDX_MODE_HI  = 6'h0F;
    localparam logic [5:0] IDX_MODE_LO  = 6'h10;
    localparam logic [5:0] IDX_RAW      = 6'h11;

    // Bit positions of the three sources and of the polarity control.
    localparam int unsigned BIT_CONV_UNDER  = 0;
    localparam int unsigned BIT_CONV_OVER   = 1;
    localparam int unsigned BIT_CLOCK_FAULT = 3;
    localparam int unsigned BIT_POLARITY    = 0;

    // Bits that hold a source; all others are reserved and read zero.
    localparam logic [7:0] SRC_BITS = 8'h0B;

    // Values after reset.
    localparam logic [7:0] RST_STATUS   = 8'h00;
    localparam logic [7:0] RST_MASK     = 8'h00;
    localparam logic [7:0] RST_MODE     = 8'h00;
    localparam logic [7:0] RST_POLARITY = 8'h00;

    // Activation mode of one source.
    typedef enum logic [1:0] {
        MODE_RISE,
        MODE_FALL,
        MODE_LEVEL,
        MODE_RSVD
    } aisl_mode_type;

endpackage

// ---- design/aisl_src_detect.sv ----
// Per-source activation detector for the event interrupt block.
`timescale 1ns/1ns
module aisl_src_detect
    import aisl_pkg::*;
#(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] cond,
    input  wire logic [WIDTH-1:0] mode_hi,
    input  wire logic [WIDTH-1:0] mode_lo,
    output logic      [WIDTH-1:0] event_hit,
    output logic      [WIDTH-1:0] level_hit
);

    typedef struct packed {
        logic [WIDTH-1:0] prev;
    } aisl_det_state_type;

    aisl_det_state_type st_r;
    aisl_det_state_type st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.prev = cond;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Each source decodes its own 2-bit code.
    for (genvar i = 0; i < WIDTH; i++) begin : g_src
        aisl_mode_type mode;
        assign mode = aisl_mode_type'({mode_hi[i], mode_lo[i]});
        always_comb begin
            event_hit[i] = 1'b0;
            level_hit[i] = 1'b0;
            unique case (mode)
                MODE_RISE: event_hit[i] = cond[i] & ~st_r.prev[i];
                MODE_FALL: event_hit[i] = ~cond[i] & st_r.prev[i];
                MODE_LEVEL: begin
                    event_hit[i] = cond[i];
                    level_hit[i] = cond[i];
                end
                MODE_RSVD: event_hit[i] = 1'b0;
            endcase
        end
    end

endmodule

// ---- design/aisl_top.sv ----
// APB register file and interrupt pin of the event interrupt block.
`timescale 1ns/1ns
module aisl_top
    import aisl_pkg::*;
#(
    parameter int unsigned ADDR_W = 8
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              clock_fault_cond,
    input  wire logic              conv_over_cond,
    input  wire logic              conv_under_cond,
    output logic                   irq,
    output logic                   int_pin_out,
    output logic                   int_pin_oe
);

    typedef struct packed {
        logic [7:0]  status;
        logic [7:0]  mask;
        logic [7:0]  mode_hi;
        logic [7:0]  mode_lo;
        logic [7:0]  polarity;
        logic [7:0]  reported;
        logic        rd_status;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
        logic        pin_out;
        logic        pin_oe;
    } aisl_state_type;

    aisl_state_type st_r;
    aisl_state_type st_nxt;

    logic [7:0] cond;
    logic [7:0] event_hit;
    logic [7:0] level_hit;

    // Live conditions placed at their status positions.
    always_comb begin
        cond                  = 8'h00;
        cond[BIT_CLOCK_FAULT] = clock_fault_cond;
        cond[BIT_CONV_OVER]   = conv_over_cond;
        cond[BIT_CONV_UNDER]  = conv_under_cond;
    end

    aisl_src_detect #(
        .WIDTH (8)
    ) u_detect (
        .pclk      (pclk),
        .presetn   (presetn),
        .cond      (cond),
        .mode_hi   (st_r.mode_hi),
        .mode_lo   (st_r.mode_lo),
        .event_hit (event_hit),
        .level_hit (level_hit)
    );

    // Bus decode.
    logic [5:0] idx;
    logic       addr_ok;
    logic       setup_ok;
    logic       access;
    logic       done;
    logic       wr_lane;

    always_comb begin
        idx      = paddr[7:2];
        addr_ok  = (paddr[1:0] == 2'h0);
        if (ADDR_W > 8) begin
            addr_ok = addr_ok && ((paddr >> 8) == '0);
        end
        access   = psel && penable && !st_r.pready;
        done     = psel && penable && st_r.pready;
        setup_ok = 1'b0;
        unique case (idx)
            IDX_POLARITY: setup_ok = addr_ok;
            IDX_STATUS:   setup_ok = addr_ok;
            IDX_MASK:     setup_ok = addr_ok;
            IDX_MODE_HI:  setup_ok = addr_ok;
            IDX_MODE_LO:  setup_ok = addr_ok;
            IDX_RAW:      setup_ok = addr_ok;
            default:      setup_ok = 1'b0;
        endcase
        wr_lane = pstrb[0];
    end

    // Read value of the selected register.
    logic [7:0] rd_val;

    always_comb begin
        rd_val = 8'h00;
        unique case (idx)
            IDX_POLARITY: rd_val = st_r.polarity;
            IDX_STATUS:   rd_val = st_r.status;
            IDX_MASK:     rd_val = st_r.mask;
            IDX_MODE_HI:  rd_val = st_r.mode_hi;
            IDX_MODE_LO:  rd_val = st_r.mode_lo;
            IDX_RAW:      rd_val = cond;
            default:      rd_val = 8'h00;
        endcase
    end

    // Next state.
    logic [7:0] gated_hit;
    logic [7:0] cleared;
    logic       any_level;
    logic       irq_nxt;

    always_comb begin
        st_nxt = st_r;

        // Answer one cycle into the access phase.
        st_nxt.pready  = access;
        st_nxt.pslverr = 1'b0;
        st_nxt.rd_status = 1'b0;
        if (access) begin
            st_nxt.pslverr = !setup_ok;
            st_nxt.prdata  = 32'h0000_0000;
            if (!pwrite && setup_ok) begin
                st_nxt.prdata[7:0] = rd_val;
            end
            if (!pwrite && setup_ok && idx == IDX_STATUS) begin
                st_nxt.rd_status = 1'b1;
                st_nxt.reported  = st_r.status;
            end
        end else if (!psel) begin
            st_nxt.prdata = 32'h0000_0000;
        end

        // Writes take effect at the edge that completes the transfer.
        if (done && pwrite && setup_ok && wr_lane) begin
            unique case (idx)
                IDX_POLARITY: begin
                    st_nxt.polarity = 8'h00;
                    st_nxt.polarity[BIT_POLARITY] = pwdata[BIT_POLARITY];
                end
                IDX_MASK:    st_nxt.mask    = pwdata[7:0] & SRC_BITS;
                IDX_MODE_HI: st_nxt.mode_hi = pwdata[7:0] & SRC_BITS;
                IDX_MODE_LO: st_nxt.mode_lo = pwdata[7:0] & SRC_BITS;
                default: begin
                end
            endcase
        end

        // Read clears only what was reported.
        cleared = st_r.status;
        if (done && st_r.rd_status) begin
            cleared = st_r.status & ~st_r.reported;
        end

        gated_hit = event_hit & st_r.mask;

        // Masked sources dropped; set wins over clear.
        st_nxt.status = (cleared | gated_hit) & st_nxt.mask & SRC_BITS;

        any_level = |(level_hit & st_r.mask);

        irq_nxt    = (|st_nxt.status) || any_level;
        st_nxt.irq = irq_nxt;

        if (st_nxt.polarity[BIT_POLARITY]) begin
            st_nxt.pin_out = irq_nxt;
            st_nxt.pin_oe  = 1'b1;
        end else begin
            st_nxt.pin_out = 1'b0;
            st_nxt.pin_oe  = irq_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r          <= '0;
            st_r.status   <= RST_STATUS;
            st_r.mask     <= RST_MASK;
            st_r.mode_hi  <= RST_MODE;
            st_r.mode_lo  <= RST_MODE;
            st_r.polarity <= RST_POLARITY;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata      = st_r.prdata;
    assign pready      = st_r.pready;
    assign pslverr     = st_r.pslverr;
    assign irq         = st_r.irq;
    assign int_pin_out = st_r.pin_out;
    assign int_pin_oe  = st_r.pin_oe;

endmodule

// ---- verification/aisl_assertions.sv ----
// Port-level checker of the event interrupt block.
`timescale 1ns/1ns
module aisl_checker #(
    parameter int unsigned ADDR_W = 8
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              clock_fault_cond,
    input wire logic              conv_over_cond,
    input wire logic              conv_under_cond,
    input wire logic              irq,
    input wire logic              int_pin_out,
    input wire logic              int_pin_oe
);
    wire logic [2:0] cnd_w = {clock_fault_cond, conv_over_cond, conv_under_cond};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_time: assert property (psel && penable && !pready |=> pready)
        else $error("access not answered in one cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready stood longer than one cycle");
    a_read_layout: assert property (pready |-> prdata[31:4] == 28'h0 && !prdata[2])
        else $error("reserved read bits not zero");
    a_pin_release: assert property (!int_pin_oe |-> !int_pin_out)
        else $error("pin driven high while released");
    a_pin_drive: assert property (irq |-> int_pin_oe)
        else $error("pin not driven while interrupt active");
    a_pin_cause: assert property (int_pin_out |-> irq)
        else $error("pin high without interrupt");
    a_irq_cause: assert property ($rose(irq) |-> $past(cnd_w) != 3'h0 || $past(cnd_w, 2) != 3'h0)
        else $error("interrupt rose without any condition");
    a_irq_quiet: assert property ($past(cnd_w) == 3'h0 && cnd_w == 3'h0 && !irq |=> !irq)
        else $error("interrupt rose while all conditions quiet");
    a_irq_sticky: assert property ($fell(irq) |-> $past(pready))
        else $error("interrupt fell without a register access");
    c_irq_rise: cover property ($rose(irq));
    c_slave_err: cover property (pslverr);
    c_pin_low: cover property (int_pin_oe && !int_pin_out);
endmodule

bind aisl_top aisl_checker #(.ADDR_W(ADDR_W)) i_aisl_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clock_fault_cond(clock_fault_cond), .conv_over_cond(conv_over_cond),
    .conv_under_cond(conv_under_cond), .irq(irq),
    .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe));

// ---- verification/aisl_host_pin.sv ----
// Host side of the interrupt pin with its board pull-up.
`timescale 1ns/1ns
module aisl_host_pin (
    input  wire logic int_pin_out,
    input  wire logic int_pin_oe,
    output logic      pin
);
    assign pin = int_pin_oe ? int_pin_out : 1'b1;
endmodule

// ---- verification/aisl_top_tb.sv ----
// Self-checking bench of the event interrupt block.
`timescale 1ns/1ns
module aisl_top_tb import aisl_pkg::*;;
    typedef struct {logic w; logic [7:0] a, d, e; logic err;} aisl_row_type;
    logic        pclk, presetn, psel, penable, pwrite, er;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb, cnd;
    logic        pready, pslverr, irq, int_pin_out, int_pin_oe, pin;
    int          error_cnt, total_checks;
    aisl_row_type rows [12] = '{'{1, 8'h38, 8'hFF, 0, 0}, '{0, 8'h38, 0, SRC_BITS, 0},
        '{1, 8'h3C, 8'hFF, 0, 0}, '{0, 8'h3C, 0, SRC_BITS, 0},
        '{1, 8'h40, 8'hF4, 0, 0}, '{0, 8'h40, 0, 8'h00, 0},
        '{1, 8'h34, 8'hFF, 0, 0}, '{0, 8'h34, 0, 8'h00, 0},
        '{0, 8'h48, 0, 8'h00, 1}, '{0, 8'h35, 0, 8'h00, 1},
        '{1, 8'h30, 8'h01, 0, 0}, '{0, 8'h30, 0, 8'h01, 0}};
    aisl_top i_aisl_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .clock_fault_cond(cnd[3]), .conv_over_cond(cnd[1]),
        .conv_under_cond(cnd[0]), .irq(irq), .int_pin_out(int_pin_out),
        .int_pin_oe(int_pin_oe));
    aisl_host_pin i_aisl_host_pin (.int_pin_out(int_pin_out),
        .int_pin_oe(int_pin_oe), .pin(pin));
    initial begin
        pclk = 0;
        forever #2 pclk = ~pclk;
    end
    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, exp, input string nm);
        total_checks++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
            error_cnt++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, d);
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata; er = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    initial begin
        wt(20000);
        error_cnt++;
        close_out;
    end
    initial begin
        psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        pstrb = 4'hF; cnd = 0; presetn = 0; error_cnt = 0; total_checks = 0;
        wt(16);
        presetn <= 1;
        for (int i = 0; i < 12; i++) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk(er, rows[i].err, "slverr");
            if (!rows[i].w) chk(rd, rows[i].e, "rdata");
        end
        for (int m = 0; m < 3; m++) begin
            apb(1, 8'h3C, m[1] ? SRC_BITS : 8'h00);
            apb(1, 8'h40, m[0] ? SRC_BITS : 8'h00);
            for (int b = 0; b < 4; b++) if (SRC_BITS[b]) begin
                cnd[b] <= 1; wt(3);
                chk(irq, m != 1, "irq during");
                chk(pin, m != 1, "pin during");
                cnd[b] <= 0; wt(3);
                chk(irq, 1, "irq after");
                apb(0, 8'h34, 0);
                chk(rd, 32'h1 << b, "status");
                wt(2);
                chk(irq, 0, "irq rearmed");
            end
        end
        apb(1, 8'h38, 8'h00);
        cnd <= 4'hB; wt(3);
        chk(irq, 0, "irq masked");
        cnd <= 0;
        apb(0, 8'h34, 0);
        chk(rd, 0, "masked status");
        apb(1, 8'h38, SRC_BITS);
        apb(1, 8'h30, 8'h00);
        cnd[0] <= 1; wt(3);
        chk(pin, 0, "pin low active");
        cnd[0] <= 0;
        apb(0, 8'h34, 0);
        wt(2);
        chk(pin, 1, "pin released");
        presetn <= 0; wt(2);
        presetn <= 1;
        for (int i = 0; i < 5; i++) begin
            apb(0, 8'h30 + 8'(4 * i), 0);
            chk(rd, 0, "reset value");
        end
        close_out;
    end
endmodule
